/* src/fbp_pkg.sv */
// Package for the flash block protection logic: register offsets, fields,
// reset values, commit indices and state types.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package fbp_pkg;
	// APB byte offsets
	localparam logic [11:0] OFF_TARGET_ADDR = 12'h000;
	localparam logic [11:0] OFF_DATA = 12'h004;
	localparam logic [11:0] OFF_CONTROL = 12'h008;
	localparam logic [11:0] OFF_RAW_STATUS = 12'h00c;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h010;
	localparam logic [11:0] OFF_STATUS_CLEAR = 12'h014;
	localparam logic [11:0] OFF_READ_ENABLE = 12'h130;
	localparam logic [11:0] OFF_PROGRAM_ENABLE = 12'h134;
	localparam logic [11:0] OFF_DEBUG_LOCK = 12'h1d0;
	// Control register key and command bit positions
	localparam logic [15:0] CONTROL_KEY = 16'ha442;
	localparam int CTL_WRITE = 0;
	localparam int CTL_ERASE = 1;
	localparam int CTL_MERASE = 2;
	localparam int CTL_COMMIT = 3;
	// Status and mask bit positions
	localparam int STAT_PROG_DONE = 0;
	localparam int STAT_ACCESS = 1;
	// Commit indices loaded into the target address register
	localparam logic [31:0] COMMIT_READ_ENABLE = 32'h0000_0000;
	localparam logic [31:0] COMMIT_PROGRAM_ENABLE = 32'h0000_0001;
	localparam logic [31:0] COMMIT_DEBUG_LOCK = 32'h7510_0000;
	// Factory values
	localparam logic [31:0] FACTORY_ENABLES = 32'hffff_ffff;
	localparam logic [31:0] FACTORY_DEBUG_LOCK = 32'hffff_fffe;
	localparam int DEBUG_UNCOMMITTED_BIT = 31;
	// Flash protection block is 2 KB
	localparam int BLOCK_SHIFT = 11;
	// Program engine operation kinds
	localparam logic [1:0] OP_WORD = 2'h0;
	localparam logic [1:0] OP_PAGE = 2'h1;
	localparam logic [1:0] OP_MASS = 2'h2;

	typedef enum logic [1:0] {
		FBP_IDLE = 2'b00,
		FBP_BUSY = 2'b01,
		FBP_CLEAR = 2'b10
	} fbp_phase_t;

	// Volatile state, restored at power-on reset
	typedef struct packed {
		fbp_phase_t phase;
		logic loaded;
		logic [31:0] targetAddr;
		logic [31:0] dataWord;
		logic [3:0] ctlBits;
		logic [1:0] rawStatus;
		logic [1:0] irqMask;
		logic [31:0] readEnable;
		logic [31:0] programEnable;
		logic [31:0] debugLock;
		logic pgmStart;
		logic [1:0] pgmKind;
		logic commitRead;
		logic commitProgram;
		logic commitDebug;
	} fbp_state_t;

	// Committed state, survives power-on reset
	typedef struct packed {
		logic [31:0] readEnable;
		logic [31:0] programEnable;
		logic [31:0] debugLock;
	} fbp_nv_t;
endpackage : fbp_pkg

/* src/flash_block_protection.sv */
// Flash block protection: per-block policy bits, commit, access checks for
// instruction, data and debug reads, program/erase gating, status and mask.
// Assumes an APB master, an external program engine and a factory-init pulse.
//
// Overview of operation
// - Two policy bits per 2-KB block.
// - Program-enable bit gates program and erase.
// - Read-enable bit gates data reads, not fetches.
// - Both zero gives execute-only.
// - Program set, read clear: no data reads.
// - Program clear, read set: read-only.
// - Both set: no protection.
// - Refused data read answers a bus fault.
// - Protected program/erase refused, access flag raised.
// - Factory value is all ones.
// - Bits only clear; power-on reset restores.
// - Commit makes cleared bits permanent.
// - Data-bus literal loads blocked, fetches allowed.
// - Debug reads refused when read disabled.
// - Debug disabled blocks access, keeps boundary scan.
// - Two debug-lock bits decide; irreversible once committed.
// - Completion and access events set status.
// - Mask gates interrupt; raw always readable.
// - Write one clears status; zero ignored.
// - Commit via index and key-plus-commit write.
// - Program/erase bit clears on completion.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module flash_block_protection #(
	parameter int BLOCKS = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic factoryInit,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Instruction bus fetch check
	input wire logic fetchValid,
	input wire logic [31:0] fetchAddr,
	output logic fetchFault,
	// Data bus read check
	input wire logic dataReadValid,
	input wire logic [31:0] dataReadAddr,
	output logic dataReadFault,
	// Debug port access check
	input wire logic dbgAccessValid,
	input wire logic dbgIsScan,
	input wire logic [31:0] dbgReadAddr,
	input wire logic dbgIsFlashRead,
	output logic dbgAccessFault,
	output logic debugEnabled,
	// Program engine
	output logic pgmStart,
	output logic [1:0] pgmKind,
	output logic [31:0] pgmAddr,
	output logic [31:0] pgmData,
	input wire logic pgmDone,
	// Controller interrupt
	output logic flashIrq
);

	fbp_pkg::fbp_state_t st_reg;
	fbp_pkg::fbp_state_t st_next;
	fbp_pkg::fbp_nv_t nv_reg;
	logic [31:0] effRead;
	logic [31:0] effProgram;
	logic [31:0] effDebug;
	logic wrEn;
	logic rdEn;
	logic mapped;
	logic accessEvent;
	logic doneEvent;

	// Policy bit for an address; blocks beyond the array read as zero
	function automatic logic policyBit(input logic [31:0] bits, input logic [31:0] addr);
		logic [31:0] blk;
		blk = addr >> fbp_pkg::BLOCK_SHIFT;
		if (blk < 32'(BLOCKS)) begin
			return bits[blk[4:0]];
		end
		return 1'b0;
	endfunction : policyBit

	// Mask of implemented blocks; mass erase checks only these bits
	function automatic logic [31:0] implMask();
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 32; i++) begin
			if (i < BLOCKS) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : implMask

	// Until the working copy is loaded after reset, use committed values
	assign effRead = st_reg.loaded ? st_reg.readEnable : nv_reg.readEnable;
	assign effProgram = st_reg.loaded ? st_reg.programEnable : nv_reg.programEnable;
	assign effDebug = nv_reg.debugLock;

	// Debug enabled only with bit b set and bit a clear, as shipped
	assign debugEnabled = effDebug[1] & ~effDebug[0];

	// Access checks; fetches ignore the read-enable bit
	assign fetchFault = fetchValid & (fetchAddr >> fbp_pkg::BLOCK_SHIFT >= 32'(BLOCKS));
	assign dataReadFault = dataReadValid & ~policyBit(effRead, dataReadAddr);
	assign dbgAccessFault = dbgAccessValid & ~dbgIsScan
		& (~debugEnabled | (dbgIsFlashRead & ~policyBit(effRead, dbgReadAddr)));

	// APB decode; zero wait states
	assign wrEn = psel & penable & pwrite;
	assign rdEn = psel & ~pwrite;
	assign pready = 1'b1;
	always_comb begin
		mapped = 1'b1;
		prdata = 32'h0000_0000;
		case (paddr)
			fbp_pkg::OFF_TARGET_ADDR: prdata = st_reg.targetAddr;
			fbp_pkg::OFF_DATA: prdata = st_reg.dataWord;
			fbp_pkg::OFF_CONTROL: prdata = {28'h000_0000, st_reg.ctlBits};
			fbp_pkg::OFF_RAW_STATUS: prdata = {30'h0000_0000, st_reg.rawStatus};
			fbp_pkg::OFF_IRQ_MASK: prdata = {30'h0000_0000, st_reg.irqMask};
			fbp_pkg::OFF_STATUS_CLEAR: prdata = {30'h0000_0000, st_reg.rawStatus & st_reg.irqMask};
			fbp_pkg::OFF_READ_ENABLE: prdata = effRead;
			fbp_pkg::OFF_PROGRAM_ENABLE: prdata = effProgram;
			fbp_pkg::OFF_DEBUG_LOCK: prdata = st_reg.debugLock;
			default: mapped = 1'b0;
		endcase
		if (!rdEn) begin
			prdata = 32'h0000_0000;
		end
	end
	assign pslverr = psel & penable & ~mapped;

	// Controller interrupt from masked status
	assign flashIrq = |(st_reg.rawStatus & st_reg.irqMask);

	// Registered outputs to the program engine
	assign pgmStart = st_reg.pgmStart;
	assign pgmKind = st_reg.pgmKind;
	assign pgmAddr = st_reg.targetAddr;
	assign pgmData = st_reg.dataWord;

	// Next-state logic
	always_comb begin
		logic [31:0] w;
		logic keyOk;
		logic allowed;
		w = pwdata;
		keyOk = 1'b0;
		allowed = 1'b0;
		st_next = st_reg;
		st_next.pgmStart = 1'b0;
		st_next.commitRead = 1'b0;
		st_next.commitProgram = 1'b0;
		st_next.commitDebug = 1'b0;
		accessEvent = 1'b0;
		doneEvent = 1'b0;
		// Reload working copy from the committed store after reset
		if (!st_reg.loaded) begin
			st_next.loaded = 1'b1;
			st_next.readEnable = nv_reg.readEnable;
			st_next.programEnable = nv_reg.programEnable;
			st_next.debugLock = nv_reg.debugLock;
		end
		// Register writes
		if (wrEn && st_reg.loaded) begin
			case (paddr)
				fbp_pkg::OFF_TARGET_ADDR: st_next.targetAddr = w;
				fbp_pkg::OFF_DATA: st_next.dataWord = w;
				fbp_pkg::OFF_IRQ_MASK: st_next.irqMask = w[1:0];
				fbp_pkg::OFF_READ_ENABLE: st_next.readEnable = st_reg.readEnable & w;
				fbp_pkg::OFF_PROGRAM_ENABLE: st_next.programEnable = st_reg.programEnable & w;
				fbp_pkg::OFF_DEBUG_LOCK: st_next.debugLock = st_reg.debugLock & w;
				fbp_pkg::OFF_STATUS_CLEAR: st_next.rawStatus = st_reg.rawStatus & ~w[1:0];
				fbp_pkg::OFF_CONTROL: keyOk = (w[31:16] == fbp_pkg::CONTROL_KEY);
				default: ;
			endcase
		end
		// Command sequencing
		case (st_reg.phase)
			fbp_pkg::FBP_IDLE: begin
				if (keyOk) begin
					if (w[fbp_pkg::CTL_COMMIT]) begin
						st_next.ctlBits = 4'h8;
						st_next.phase = fbp_pkg::FBP_CLEAR;
						case (st_reg.targetAddr)
							fbp_pkg::COMMIT_READ_ENABLE: st_next.commitRead = 1'b1;
							fbp_pkg::COMMIT_PROGRAM_ENABLE: st_next.commitProgram = 1'b1;
							fbp_pkg::COMMIT_DEBUG_LOCK: st_next.commitDebug = 1'b1;
							default: ;
						endcase
					end else if (w[2:0] != 3'h0) begin
						if (w[fbp_pkg::CTL_MERASE]) begin
							st_next.pgmKind = fbp_pkg::OP_MASS;
							allowed = &(effProgram | ~implMask());
						end else begin
							st_next.pgmKind = w[fbp_pkg::CTL_ERASE] ? fbp_pkg::OP_PAGE
								: fbp_pkg::OP_WORD;
							allowed = policyBit(effProgram, st_reg.targetAddr);
						end
						if (allowed) begin
							st_next.ctlBits = {1'b0, w[2:0]};
							st_next.pgmStart = 1'b1;
							st_next.phase = fbp_pkg::FBP_BUSY;
						end else begin
							accessEvent = 1'b1;
						end
					end
				end
			end
			fbp_pkg::FBP_BUSY: begin
				if (pgmDone) begin
					st_next.ctlBits = 4'h0;
					doneEvent = 1'b1;
					st_next.phase = fbp_pkg::FBP_IDLE;
				end
			end
			fbp_pkg::FBP_CLEAR: begin
				st_next.ctlBits = 4'h0;
				st_next.phase = fbp_pkg::FBP_IDLE;
			end
			default: st_next.phase = fbp_pkg::FBP_IDLE;
		endcase
		// Events set after any clear so a coincident set wins
		if (doneEvent) begin
			st_next.rawStatus[fbp_pkg::STAT_PROG_DONE] = 1'b1;
		end
		if (accessEvent) begin
			st_next.rawStatus[fbp_pkg::STAT_ACCESS] = 1'b1;
		end
	end

	// Volatile state, power-on reset restores factory-shaped defaults
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.readEnable <= fbp_pkg::FACTORY_ENABLES;
			st_reg.programEnable <= fbp_pkg::FACTORY_ENABLES;
			st_reg.debugLock <= fbp_pkg::FACTORY_DEBUG_LOCK;
		end else begin
			st_reg <= st_next;
		end
	end

	// Committed store: untouched by rst, only factoryInit loads the factory values
	always_ff @(posedge clk or posedge factoryInit) begin
		if (factoryInit) begin
			nv_reg.readEnable <= fbp_pkg::FACTORY_ENABLES;
			nv_reg.programEnable <= fbp_pkg::FACTORY_ENABLES;
			nv_reg.debugLock <= fbp_pkg::FACTORY_DEBUG_LOCK;
		end else begin
			if (st_reg.commitRead) begin
				nv_reg.readEnable <= nv_reg.readEnable & st_reg.readEnable;
			end
			if (st_reg.commitProgram) begin
				nv_reg.programEnable <= nv_reg.programEnable & st_reg.programEnable;
			end
			// Debug word commits once, from the data register
			if (st_reg.commitDebug && nv_reg.debugLock[fbp_pkg::DEBUG_UNCOMMITTED_BIT]) begin
				nv_reg.debugLock <= nv_reg.debugLock & st_reg.dataWord
					& ~(32'h1 << fbp_pkg::DEBUG_UNCOMMITTED_BIT);
			end
		end
	end

endmodule : flash_block_protection

`default_nettype wire

/* tb/fbp_monitor.sv */
// Checker on the protection block ports: starts, checks, interrupt.
// Bound onto every flash_block_protection instance.
`timescale 1ns/10ps
`default_nettype none
module fbp_monitor #(
	parameter int BLOCKS = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic fetchValid,
	input wire logic [31:0] fetchAddr,
	input wire logic fetchFault,
	input wire logic dataReadValid,
	input wire logic [31:0] dataReadAddr,
	input wire logic dataReadFault,
	input wire logic dbgAccessValid,
	input wire logic dbgIsScan,
	input wire logic dbgAccessFault,
	input wire logic debugEnabled,
	input wire logic pgmStart,
	input wire logic pgmDone,
	input wire logic flashIrq
);
	localparam logic [31:0] LIMIT = 32'(BLOCKS * 2048);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Register write completing at this edge
	sequence sWr(logic [11:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	AST_PULSE: assert property (pgmStart |=> !pgmStart)
		else $error("start held over one cycle");
	AST_NOKEY: assert property (sWr(fbp_pkg::OFF_CONTROL) ##0
		pwdata[31:16] != fbp_pkg::CONTROL_KEY |=> !pgmStart) else $error("keyless start");
	AST_DFAULT: assert property (dataReadValid && dataReadAddr >= LIMIT |-> dataReadFault)
		else $error("read of absent block not faulted");
	AST_FETCH: assert property (fetchValid |-> fetchFault == (fetchAddr >= LIMIT))
		else $error("fetch fault wrong");
	AST_SCAN: assert property (dbgAccessValid && dbgIsScan |-> !dbgAccessFault)
		else $error("scan refused");
	AST_DBGOFF: assert property (dbgAccessValid && !dbgIsScan && !debugEnabled |-> dbgAccessFault)
		else $error("debug access while disabled");
	AST_CLR: assert property (sWr(fbp_pkg::OFF_STATUS_CLEAR) ##0
		pwdata[1:0] == 2'h3 && !pgmDone |=> !flashIrq) else $error("clear left irq");
	AST_MASK0: assert property (sWr(fbp_pkg::OFF_IRQ_MASK) ##0
		pwdata[1:0] == 2'h0 |=> !flashIrq) else $error("masked irq raised");
endmodule : fbp_monitor
bind flash_block_protection fbp_monitor #(.BLOCKS(BLOCKS)) mon (
	.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .fetchValid, .fetchAddr,
	.fetchFault, .dataReadValid, .dataReadAddr, .dataReadFault, .dbgAccessValid,
	.dbgIsScan, .dbgAccessFault, .debugEnabled, .pgmStart, .pgmDone, .flashIrq
);
`default_nettype wire

/* tb/fbp_engine_model.sv */
// Program engine model: answers each start with a done pulse.
// Assumes starts come only while idle.
`timescale 1ns/10ps
`default_nettype none
module fbp_engine_model #(
	parameter int DELAY = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic pgmStart,
	output logic pgmDone
);
	int count;
	// Count down from a start, then pulse done for one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= 0;
			pgmDone <= 1'b0;
		end else begin
			pgmDone <= (count == 1);
			count <= pgmStart ? DELAY : (count > 0 ? count - 1 : 0);
		end
	end
endmodule : fbp_engine_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench: register table, policy checks, power-on resets.
// Assumes the engine model and the bound monitor beside the block.
`timescale 1ns/10ps
`default_nettype none
module tb;
	typedef struct {
		int k;
		logic [11:0] a;
		logic [31:0] v;
		bit q;
	} fbp_row_t;
	localparam int BLOCKS = 32;
	localparam logic [11:0] RE = fbp_pkg::OFF_READ_ENABLE;
	localparam logic [11:0] PE = fbp_pkg::OFF_PROGRAM_ENABLE;
	localparam logic [11:0] CTL = fbp_pkg::OFF_CONTROL;
	localparam logic [11:0] TGT = fbp_pkg::OFF_TARGET_ADDR;
	localparam logic [11:0] MSK = fbp_pkg::OFF_IRQ_MASK;
	localparam logic [11:0] CLR = fbp_pkg::OFF_STATUS_CLEAR;
	localparam logic [11:0] RAW = fbp_pkg::OFF_RAW_STATUS;
	logic clk = 1'b0, rst = 1'b1, factoryInit = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, fetchValid = 1'b0, dataReadValid = 1'b0, dbgAccessValid = 1'b0;
	logic dbgIsScan = 1'b0, dbgIsFlashRead = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, fetchAddr = 32'h0, dataReadAddr = 32'h0, dbgReadAddr = 32'h0;
	logic [31:0] rd, prdata;
	logic pready, pslverr, fetchFault, dataReadFault, dbgAccessFault, debugEnabled;
	logic pgmStart, pgmDone, flashIrq;
	logic [1:0] pgmKind, lastKind;
	logic [31:0] pgmAddr, pgmData, lastAddr, lastData;
	int badCount = 0, compares = 0, starts = 0;
	// Kinds: 0 write, 1 read, 2 poll, 3 probe (a: scan, faults), 4 power-on reset
	fbp_row_t rows [49] = '{
		'{1, RE, 32'hffffffff, 0}, '{1, PE, 32'hffffffff, 0},
		'{1, fbp_pkg::OFF_DEBUG_LOCK, 32'hfffffffe, 0},
		'{0, RE, 32'hfffffffc, 0}, '{0, RE, 32'hffffffff, 0}, '{1, RE, 32'hfffffffc, 0},
		'{0, PE, 32'hfffffff9, 0}, '{1, PE, 32'hfffffff9, 0},
		'{3, 12'h003, 32'h0, 0}, '{3, 12'h003, 32'h800, 0},
		'{3, 12'h000, 32'h1000, 0}, '{3, 12'h000, 32'h1800, 0},
		'{3, 12'h007, 32'h10000, 0}, '{3, 12'h00a, 32'h0, 0},
		'{0, TGT, 32'h800, 0}, '{0, CTL, 32'ha4420001, 0}, '{1, CTL, 32'h0, 0},
		'{0, MSK, 32'h2, 1}, '{1, CLR, 32'h2, 1}, '{0, MSK, 32'h0, 0},
		'{1, RAW, 32'h2, 0}, '{0, MSK, 32'h3, 1},
		'{0, CLR, 32'h0, 1}, '{0, CLR, 32'h2, 0},
		'{0, TGT, 32'h0, 0}, '{0, CTL, 32'ha4420001, 0}, '{2, CTL, 32'h0, 1},
		'{0, CTL, 32'ha4420002, 1}, '{2, CTL, 32'h0, 1}, '{1, RAW, 32'h1, 1},
		'{0, MSK, 32'h1, 1}, '{0, CTL, 32'ha4420004, 1},
		'{0, CTL, 32'h1, 1}, '{1, RAW, 32'h3, 1}, '{0, CLR, 32'h3, 0},
		'{4, 12'h0, 32'h0, 0}, '{1, RE, 32'hffffffff, 0}, '{0, RE, 32'hfffffffe, 0},
		'{0, TGT, 32'h0, 0}, '{0, CTL, 32'ha4420008, 0}, '{2, CTL, 32'h0, 0},
		'{4, 12'h0, 32'h0, 0}, '{1, RE, 32'hfffffffe, 0}, '{1, PE, 32'hffffffff, 0},
		'{0, TGT, 32'h75100000, 0}, '{0, CTL, 32'ha4420008, 0}, '{2, CTL, 32'h0, 0},
		'{3, 12'h001, 32'h1000, 0}, '{3, 12'h008, 32'h1000, 0}
	};
	flash_block_protection #(.BLOCKS(BLOCKS)) dut (
		.clk, .rst, .factoryInit, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .fetchValid, .fetchAddr, .fetchFault,
		.dataReadValid, .dataReadAddr, .dataReadFault, .dbgAccessValid, .dbgIsScan,
		.dbgReadAddr, .dbgIsFlashRead, .dbgAccessFault, .debugEnabled, .pgmStart,
		.pgmKind, .pgmAddr, .pgmData, .pgmDone, .flashIrq
	);
	fbp_engine_model eng (.clk, .rst, .pgmStart, .pgmDone);
	// Clock and start counter
	always #50 clk = ~clk;
	always @(posedge clk) if (pgmStart === 1'b1) begin
		starts <= starts + 1;
		lastKind <= pgmKind;
		lastAddr <= pgmAddr;
		lastData <= pgmData;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer, held until pready at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic step(input fbp_row_t r);
		if (r.k == 4) begin
			@(posedge clk);
			rst <= 1'b1;
			repeat (3) @(posedge clk);
			rst <= 1'b0;
			repeat (3) @(posedge clk);
		end else if (r.k == 3) begin
			@(posedge clk);
			{fetchValid, dataReadValid, dbgAccessValid, dbgIsScan} <= {3'h7, r.a[3]};
			{fetchAddr, dataReadAddr, dbgReadAddr, dbgIsFlashRead} <= {{3{r.v}}, !r.a[3]};
			@(negedge clk);
			chk(32'({fetchFault, dataReadFault, dbgAccessFault}), 32'(r.a[2:0]));
		end else begin
			apb(r.k == 0, r.a, r.v);
			for (int i = 0; i < 60 && r.k == 2 && rd !== r.v; i++) apb(1'b0, r.a, 32'h0);
			if (r.k != 0) chk(rd, r.v);
		end
		@(negedge clk);
		chk(32'(flashIrq), 32'(r.q));
		$display("row done at %0t", $time);
	endtask : step
	task automatic tallyAndFinish();
		$display("compares %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tallyAndFinish
	// Main sequence: reset, table, then hand checks
	initial begin
		repeat (2) @(posedge clk);
		factoryInit <= 1'b0;
		repeat (18) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(debugEnabled), 32'h1);
		foreach (rows[i]) step(rows[i]);
		chk(32'(debugEnabled), 32'h0);
		chk(starts, 32'h2);
		chk(32'(lastKind), 32'(fbp_pkg::OP_PAGE));
		chk(lastAddr, 32'h0);
		chk(lastData, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("hand checks done");
		tallyAndFinish();
	end
	// Cuts a hang short well past the expected run
	initial begin
		#1000000;
		badCount++;
		tallyAndFinish();
	end
endmodule : tb
`default_nettype wire
